// [verilog/irq_mux_mode_select.sv]
// Purpose: Interrupt multiplexer with routing and port mode registers
// Assumes: Bus strobes, phase select and interrupt pins are asynchronous
// Notes:   Registers sit behind an index at port 3 and a window at port 7
`timescale 1ns/1ps
`default_nettype none
module irq_mux_mode_select
   import irq_mux_pkg::*;
#(
   parameter logic [7:0] VERSION_CODE = 8'h5a // Arbitrary value
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        cs_n,
   input  wire logic        ior_n,
   input  wire logic        iow_n,
   input  wire logic [2:0]  addr,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  data_out,
   output logic             data_oe,
   input  wire logic [2:0]  mux_phase_sel,
   input  wire logic        irq3_in,
   input  wire logic        irq4_in,
   input  wire logic        irq5_in,
   input  wire logic        irq6_in,
   input  wire logic        irq7_in,
   input  wire logic        irq8_in,
   input  wire logic        irq9_in,
   input  wire logic        irq10_in,
   input  wire logic        irq11_in,
   input  wire logic        irq12_in,
   input  wire logic        irq14_in,
   input  wire logic        irq15_in,
   input  wire logic        keyboard_irq_in,
   input  wire logic        rom_irq_in,
   input  wire logic        cpu_reset_req_in,
   input  wire logic        gate_a20_in,
   input  wire logic        sp0_irq,
   input  wire logic        sp1_irq,
   input  wire logic        pp_irq,
   input  wire logic [1:0]  sp0_modem_ctrl,
   input  wire logic [1:0]  sp1_modem_ctrl,
   input  wire logic        pp_irq_enable,
   input  wire logic        port_fifo_enable0,
   input  wire logic        port_fifo_enable1,
   output logic             mux_out_a,
   output logic             mux_out_a_oe,
   output logic             mux_out_b,
   output logic             mux_out_b_oe,
   output logic             irq7_out,
   output logic             irq7_oe,
   output logic             ports_powerdown,
   output logic             pp_irq_style,
   output logic             pp_extended_bus,
   output logic             sp0_fifo_mode,
   output logic             sp1_fifo_mode
);
   localparam int NSLOT  = 16;
   localparam int SYNC_W = 3 + 3 + 3 + 8 + NSLOT;
   // Idle levels, so the high-going stretch sees no false edge after reset
   localparam logic [SYNC_W-1:0] SYNC_IDLE =
      {{(SYNC_W - NSLOT){1'b1}}, ~STRETCH_HIGH};
   // Pin bundle, two flip-flops deep before any logic reads it
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] sync_reg;
   logic [NSLOT-1:0]  slot_raw;
   logic [NSLOT-1:0]  slot_sync;
   logic [NSLOT-1:0]  slot_shaped;
   logic [2:0]        phase_s;
   logic              cs_s;
   logic              ior_s;
   logic              iow_s;
   logic [2:0]        addr_s;
   logic [7:0]        din_s;
   logic              iow_prev_reg;
   logic              phase0_prev_reg;
   logic              edge_en;
   logic              wr_strobe;
   logic              rd_sel;
   logic [7:0]        rd_mux;
   logic [7:0]         index_reg;
   logic [FIELD_W-1:0] mode_reg;
   logic [FIELD_W-1:0] sp0_route_reg;
   logic [FIELD_W-1:0] sp1_route_reg;
   logic [FIELD_W-1:0] pp_route_reg;
   logic [7:0]         data_out_reg;
   logic               data_oe_reg;
   logic               out_a_reg;
   logic               out_b_reg;
   logic               oe_a_reg;
   logic               oe_b_reg;
   logic               irq7_reg;
   logic               irq7_oe_reg;
   logic              standalone;
   logic              sp0_route_en;
   logic              sp1_route_en;
   logic              pp_route_en;
   logic [NSLOT-1:0]  mixed;
   logic [3:0]        slot_a;
   logic [3:0]        slot_b;
   assign slot_raw[7:0] = {irq15_in, irq14_in, cpu_reset_req_in,
                           rom_irq_in, irq11_in, irq10_in, irq9_in,
                           irq8_in};
   assign slot_raw[15:8] = {irq7_in, irq6_in, irq5_in, irq4_in,
                            irq3_in, gate_a20_in, keyboard_irq_in,
                            irq12_in};

   assign pins_raw = {mux_phase_sel, cs_n, ior_n, iow_n, addr, data_in,
                      slot_raw};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_reg <= SYNC_IDLE;
         sync_reg <= SYNC_IDLE;
      end else begin
         meta_reg <= pins_raw;
         sync_reg <= meta_reg;
      end
   end

   assign {phase_s, cs_s, ior_s, iow_s, addr_s, din_s, slot_sync} = sync_reg;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         iow_prev_reg    <= 1'b1;
         phase0_prev_reg <= 1'b1;
      end else begin
         iow_prev_reg    <= iow_s;
         phase0_prev_reg <= phase_s[0];
      end
   end

   // Stretch timing counts rising edges of phase select bit 0
   assign edge_en = phase_s[0] && !phase0_prev_reg;

   // Data is taken at the falling write strobe, so it must already be set
   assign wr_strobe = !cs_s && !iow_s && iow_prev_reg;
   assign rd_sel    = !cs_s && !ior_s &&
                      (addr_s == PORT_INDEX || addr_s == PORT_DATA);

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         index_reg <= INDEX_RESET;
      else if (wr_strobe && addr_s == PORT_INDEX)
         index_reg <= din_s;
   end

   // These registers are the ones a port power-down leaves intact
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_reg      <= FIELD_RESET;
         sp0_route_reg <= FIELD_RESET;
         sp1_route_reg <= FIELD_RESET;
         pp_route_reg  <= FIELD_RESET;
      end else if (wr_strobe && addr_s == PORT_DATA) begin
         unique case (index_reg[2:0])
            IDX_SP0:  sp0_route_reg <= din_s[FIELD_W-1:0];
            IDX_SP1:  sp1_route_reg <= din_s[FIELD_W-1:0];
            IDX_PP:   pp_route_reg  <= din_s[FIELD_W-1:0];
            IDX_MODE: mode_reg      <= din_s[FIELD_W-1:0];
            default:  ;
         endcase
      end
   end

   // Reserved upper bits of the four field registers read back as zero; the index reads back all eight bits
   always_comb begin
      rd_mux = 8'h00;
      if (addr_s == PORT_INDEX)
         rd_mux = index_reg;
      else begin
         unique case (index_reg[2:0])
            IDX_SP0:  rd_mux = {4'h0, sp0_route_reg};
            IDX_SP1:  rd_mux = {4'h0, sp1_route_reg};
            IDX_PP:   rd_mux = {4'h0, pp_route_reg};
            IDX_MODE: rd_mux = {4'h0, mode_reg};
            IDX_VER:  rd_mux = VERSION_CODE;
            default:  rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         data_out_reg <= 8'h00;
         data_oe_reg  <= 1'b0;
      end else begin
         data_out_reg <= rd_mux;
         data_oe_reg  <= rd_sel;
      end
   end

   assign data_out = data_out_reg;
   assign data_oe  = data_oe_reg;
   assign ports_powerdown = mode_reg[MODE_PWRDN];
   assign pp_irq_style    = mode_reg[MODE_PPIRQ];
   assign pp_extended_bus = mode_reg[MODE_PPBUS];
   assign sp0_fifo_mode = mode_reg[MODE_FIFO] && port_fifo_enable0;
   assign sp1_fifo_mode = mode_reg[MODE_FIFO] && port_fifo_enable1;

   for (genvar i = 0; i < NSLOT; i++) begin : g_slot
      if (STRETCH_LOW[i] || STRETCH_HIGH[i]) begin : g_ext
         irq_pulse_stretch #(
            .ACTIVE_HIGH (STRETCH_HIGH[i]),
            .LEAD        (LEAD_EDGES),
            .TRAIL       (TRAIL_EDGES)
         ) u_stretch (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .edge_en  (edge_en),
            .line_in  (slot_sync[i]),
            .line_out (slot_shaped[i])
         );
      end else begin : g_pass
         assign slot_shaped[i] = slot_sync[i];
      end
   end

   assign standalone = (sp0_route_reg == ROUTE_ALONE);

   assign sp0_route_en = !sp0_modem_ctrl[MCR_HI] && sp0_modem_ctrl[MCR_LO]
                         && route_ok(sp0_route_reg);
   assign sp1_route_en = !sp1_modem_ctrl[MCR_HI] && sp1_modem_ctrl[MCR_LO]
                         && route_ok(sp1_route_reg);
   assign pp_route_en  = pp_irq_enable && route_ok(pp_route_reg);

   // Later assignments win, so no input ever sees two sources ORed
   always_comb begin
      mixed = slot_shaped;
      if (sp0_route_en)
         mixed[route_slot(sp0_route_reg)] = sp0_irq;
      if (sp1_route_en)
         mixed[route_slot(sp1_route_reg)] = sp1_irq;
      if (pp_route_en)
         mixed[route_slot(pp_route_reg)] = pp_irq;
   end

   assign slot_a = {1'b0, phase_s};
   assign slot_b = {1'b1, phase_s};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_a_reg   <= 1'b0;
         out_b_reg   <= 1'b0;
         oe_a_reg    <= 1'b0;
         oe_b_reg    <= 1'b0;
         irq7_reg    <= 1'b0;
         irq7_oe_reg <= 1'b0;
      end else if (standalone) begin
         out_a_reg   <= sp0_irq;
         out_b_reg   <= sp1_irq;
         oe_a_reg    <= sp0_modem_ctrl[MCR_LO];
         oe_b_reg    <= sp1_modem_ctrl[MCR_LO];
         irq7_reg    <= pp_irq;
         irq7_oe_reg <= pp_irq_enable;
      end else begin
         out_a_reg   <= mixed[slot_a];
         out_b_reg   <= mixed[slot_b];
         oe_a_reg    <= 1'b1;
         oe_b_reg    <= 1'b1;
         irq7_reg    <= 1'b0;
         irq7_oe_reg <= 1'b0;
      end
   end

   assign mux_out_a    = out_a_reg;
   assign mux_out_a_oe = oe_a_reg;
   assign mux_out_b    = out_b_reg;
   assign mux_out_b_oe = oe_b_reg;
   assign irq7_out     = irq7_reg;
   assign irq7_oe      = irq7_oe_reg;

   a_mode_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_sel && addr_s == PORT_DATA && index_reg[2:0] == IDX_MODE
      |=> data_oe && data_out == {4'h0, $past(mode_reg)})
      else $error("mode register not read through window");

   a_mode_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_strobe && addr_s == PORT_DATA && index_reg[2:0] == IDX_MODE
      |=> ports_powerdown == $past(din_s[MODE_PWRDN])
          && pp_extended_bus == $past(din_s[MODE_PPBUS]))
      else $error("mode write did not steer ports");

   a_fifo_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !mode_reg[MODE_FIFO] |-> !sp0_fifo_mode && !sp1_fifo_mode)
      else $error("FIFO mode without permission");

   a_rom_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !standalone && phase_s == SLOT_ROM[2:0] && !pp_route_en
      && !sp0_route_en && !sp1_route_en
      |=> mux_out_a == $past(slot_sync[SLOT_ROM]))
      else $error("ROM interrupt not on output a phase 4");

   a_a20_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !standalone && phase_s == SLOT_A20[2:0]
      |=> mux_out_b == $past(slot_sync[SLOT_A20]))
      else $error("A20 gate not on output b phase 2");

   a_alone_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
      standalone |=> mux_out_a == $past(sp0_irq)
         && mux_out_b_oe == $past(sp1_modem_ctrl[MCR_LO])
         && irq7_oe == $past(pp_irq_enable))
      else $error("stand-alone outputs wrong");

   a_serial1_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sp0_route_en && sp1_route_en && !pp_route_en
      && sp0_route_reg == sp1_route_reg
      |-> mixed[route_slot(sp1_route_reg)] == sp1_irq)
      else $error("serial 1 did not win the input");

   a_parallel_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pp_route_en |-> mixed[route_slot(pp_route_reg)] == pp_irq)
      else $error("parallel did not win the input");

   a_route_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sp0_modem_ctrl[MCR_HI] && !sp1_route_en && !pp_route_en
      |-> mixed == slot_shaped)
      else $error("route acted while disabled");
endmodule // irq_mux_mode_select
`default_nettype wire

// [pkg/irq_mux_pkg.sv]
// Purpose: Shared constants for the interrupt multiplexer and mode block
// Assumes: Three-bit port address, eight-bit port data
// Notes:   Route codes 1 to 9 map onto nine multiplexer slots between 2 and 15
`default_nettype none
package irq_mux_pkg;
   // Port addresses of the index and data window
   localparam logic [2:0] PORT_INDEX = 3'h3;
   localparam logic [2:0] PORT_DATA  = 3'h7;
   // Values of the register index field
   localparam logic [2:0] IDX_SP0  = 3'h2;
   localparam logic [2:0] IDX_SP1  = 3'h3;
   localparam logic [2:0] IDX_PP   = 3'h4;
   localparam logic [2:0] IDX_MODE = 3'h5;
   localparam logic [2:0] IDX_VER  = 3'h6;
   // Mode register bit positions
   localparam int MODE_FIFO  = 0;
   localparam int MODE_PPBUS = 1;
   localparam int MODE_PPIRQ = 2;
   localparam int MODE_PWRDN = 3;
   // Modem control pair: bit 1 is control bit 4, bit 0 is control bit 3
   localparam int MCR_HI = 1;
   localparam int MCR_LO = 0;
   localparam int FIELD_W = 4;
   localparam logic [3:0] FIELD_RESET = 4'h0;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [3:0] ROUTE_OFF   = 4'h0;
   localparam logic [3:0] ROUTE_LAST  = 4'h9;
   localparam logic [3:0] ROUTE_ALONE = 4'hf;
   // Pulse extension edge counts on phase select bit 0
   localparam int LEAD_EDGES  = 5;
   localparam int TRAIL_EDGES = 3;
   // Slot numbers: 0-7 feed output a, 8-15 feed output b
   localparam logic [3:0] SLOT_IRQ10 = 4'h2;
   localparam logic [3:0] SLOT_IRQ11 = 4'h3;
   localparam logic [3:0] SLOT_ROM   = 4'h4;
   localparam logic [3:0] SLOT_IRQ15 = 4'h7;
   localparam logic [3:0] SLOT_A20   = 4'ha;
   localparam logic [3:0] SLOT_IRQ3  = 4'hb;
   localparam logic [3:0] SLOT_IRQ4  = 4'hc;
   localparam logic [3:0] SLOT_IRQ5  = 4'hd;
   localparam logic [3:0] SLOT_IRQ6  = 4'he;
   localparam logic [3:0] SLOT_IRQ7  = 4'hf;
   // Slots widened low-going, and the one widened high-going
   localparam logic [15:0] STRETCH_LOW  = 16'hfbce;
   localparam logic [15:0] STRETCH_HIGH = 16'h0001;

   function automatic logic [3:0] route_slot(input logic [3:0] code);
      logic [3:0] s;
      s = SLOT_IRQ3;
      unique case (code)
         4'h2:    s = SLOT_IRQ4;
         4'h3:    s = SLOT_IRQ5;
         4'h4:    s = SLOT_IRQ6;
         4'h5:    s = SLOT_IRQ7;
         4'h6:    s = SLOT_IRQ10;
         4'h7:    s = SLOT_IRQ11;
         4'h8:    s = SLOT_ROM;
         4'h9:    s = SLOT_IRQ15;
         default: s = SLOT_IRQ3;
      endcase
      return s;
   endfunction

   function automatic logic route_ok(input logic [3:0] code);
      return (code != ROUTE_OFF) && (code <= ROUTE_LAST);
   endfunction
endpackage
`default_nettype wire

// [verilog/irq_pulse_stretch.sv]
// Purpose: Widens pulses on one interrupt line by edge counts
// Assumes: Input already synchronised; edge_en marks a phase bit 0 rise
// Notes:   Short returns to idle inside a stretch are swallowed
`timescale 1ns/1ps
`default_nettype none
module irq_pulse_stretch #(
   parameter bit ACTIVE_HIGH = 1'b0,
   parameter int LEAD        = 5,
   parameter int TRAIL       = 3
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic edge_en,
   input  wire logic line_in,
   output logic      line_out
);
   localparam int CW = 3;
   localparam logic [CW-1:0] LEAD_CNT  = CW'(LEAD);
   localparam logic [CW-1:0] TRAIL_CNT = CW'(TRAIL);
   localparam logic [CW-1:0] ZERO      = '0;
   localparam logic [CW-1:0] ONE       = CW'(1);

   logic          act_in;
   logic          act_reg;
   logic [CW-1:0] lead_reg;
   logic [CW-1:0] trail_reg;

   assign act_in   = ACTIVE_HIGH ? line_in : ~line_in;
   assign line_out = ACTIVE_HIGH ? act_reg : ~act_reg;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         act_reg   <= 1'b0;
         lead_reg  <= ZERO;
         trail_reg <= ZERO;
      end else if (act_in && !act_reg) begin
         act_reg   <= 1'b1;
         lead_reg  <= LEAD_CNT;
         trail_reg <= TRAIL_CNT;
      end else if (act_reg) begin
         if (edge_en && lead_reg != ZERO)
            lead_reg <= lead_reg - ONE;
         if (act_in)
            trail_reg <= TRAIL_CNT;
         else if (edge_en && trail_reg != ZERO)
            trail_reg <= trail_reg - ONE;
         if (!act_in && edge_en && trail_reg <= ONE && lead_reg <= ONE)
            act_reg <= 1'b0;
      end
   end

   a_stretch_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(act_reg) |-> $past(edge_en) && !$past(act_in)
         && $past(trail_reg) <= ONE && $past(lead_reg) <= ONE)
      else $error("stretched pulse ended early");

   a_stretch_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(act_reg) |-> lead_reg == LEAD_CNT && trail_reg == TRAIL_CNT)
      else $error("stretch counters not loaded");
endmodule // irq_pulse_stretch
`default_nettype wire

// [tb/phase_sequencer.sv]
// Purpose: Phase select sequencer standing in for the system controller
// Assumes: Steps on sys_clk; hold and mask come from the bench
// Notes:   A long hold lets the bench sample the mux within each step
`timescale 1ns/1ps
`default_nettype none
module phase_sequencer (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] hold,
   input  wire logic [2:0] mask,
   output logic      [2:0] mux_phase_sel
);
   logic [7:0] wait_reg;
   logic [2:0] step_reg;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wait_reg <= 8'h00;
         step_reg <= 3'h0;
      end else if (wait_reg >= hold) begin
         wait_reg <= 8'h00;
         step_reg <= step_reg + 3'h1;
      end else begin
         wait_reg <= wait_reg + 8'h01;
      end
   end
   // Masking bits keeps the walk on a few phases for stretch tests
   assign mux_phase_sel = step_reg & mask;
endmodule // phase_sequencer
`default_nettype wire

// [tb/irq_mux_mode_select_test.sv]
// Purpose: Self-checking bench for the interrupt mux and mode block
// Assumes: Bus strobes held four cycles, phase steps of seven or more
// Notes:   Slot vector drives the sixteen mux inputs in mux order
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   miscompares++; $display("unexpected %s expected %h seen %h", n, e, g); \
   end end
module irq_mux_mode_select_test;
   import irq_mux_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, ior_n = 1'b1;
   logic iow_n = 1'b1, sp0_irq = 1'b0, sp1_irq = 1'b0, pp_irq = 1'b0;
   logic pp_en = 1'b0, fe0 = 1'b0, fe1 = 1'b0, a_oe, b_oe, i7, i7_oe;
   logic mux_out_a, mux_out_b, pd, ps, pb, f0, f1, data_oe;
   logic [2:0] addr = 3'h0, mask = 3'h7, ph;
   logic [1:0] mc0 = 2'h1, mc1 = 2'h1;
   logic [7:0] data_in = 8'h00, data_out, hold = 8'h06, q;
   logic [15:0] slots = 16'h0000;
   int miscompares = 0, check_count = 0;
   logic [31:0] rows [4] = '{32'h0, 32'hffff_ffff, 32'hc3a5_a5c3,
                             32'h3c5a_5a3c};
   logic [3:0] slot_of [10] = '{4'h0, 4'hb, 4'hc, 4'hd, 4'he, 4'hf,
                                4'h2, 4'h3, 4'h4, 4'h7};
   logic [7:0] modes [4] = '{8'h0f, 8'h0a, 8'h05, 8'h01};
   always #10 sys_clk = ~sys_clk;
   phase_sequencer seq (.sys_clk(sys_clk), .rst_n(rst_n), .hold(hold),
      .mask(mask), .mux_phase_sel(ph));
   irq_mux_mode_select dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
      .ior_n(ior_n), .iow_n(iow_n), .addr(addr), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .mux_phase_sel(ph),
      .irq8_in(slots[0]), .irq9_in(slots[1]), .irq10_in(slots[2]),
      .irq11_in(slots[3]), .rom_irq_in(slots[4]),
      .cpu_reset_req_in(slots[5]), .irq14_in(slots[6]),
      .irq15_in(slots[7]), .irq12_in(slots[8]),
      .keyboard_irq_in(slots[9]), .gate_a20_in(slots[10]),
      .irq3_in(slots[11]), .irq4_in(slots[12]), .irq5_in(slots[13]),
      .irq6_in(slots[14]), .irq7_in(slots[15]), .sp0_irq(sp0_irq),
      .sp1_irq(sp1_irq), .pp_irq(pp_irq), .sp0_modem_ctrl(mc0),
      .sp1_modem_ctrl(mc1), .pp_irq_enable(pp_en),
      .port_fifo_enable0(fe0), .port_fifo_enable1(fe1),
      .mux_out_a(mux_out_a), .mux_out_a_oe(a_oe), .mux_out_b(mux_out_b),
      .mux_out_b_oe(b_oe), .irq7_out(i7), .irq7_oe(i7_oe),
      .ports_powerdown(pd), .pp_irq_style(ps), .pp_extended_bus(pb),
      .sp0_fifo_mode(f0), .sp1_fifo_mode(f1));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Strobes stay low four cycles; the synchroniser needs three
   task automatic bus(input logic [2:0] a, input logic [7:0] d,
                      input logic rd, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge sys_clk); #1;
      addr = a; data_in = d; cs_n = 1'b0;
      @(posedge sys_clk); #1;
      ior_n = !rd; iow_n = rd;
      repeat (4) @(posedge sys_clk);
      #1;
      while (rd && data_oe !== 1'b1 && n < 20) begin
         @(posedge sys_clk); #1; n++;
      end
      if (n >= 20) begin miscompares++; give_verdict(); end
      r = data_out;
      ior_n = 1'b1; iow_n = 1'b1;
      @(posedge sys_clk); #1; cs_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   task automatic reg_wr(input logic [2:0] i, input logic [7:0] v);
      bus(PORT_INDEX, {5'h00, i}, 1'b0, q);
      bus(PORT_DATA, v, 1'b0, q);
   endtask
   task automatic reg_rd(input logic [2:0] i, output logic [7:0] v);
      bus(PORT_INDEX, {5'h00, i}, 1'b0, q);
      bus(PORT_DATA, 8'h00, 1'b1, v);
   endtask
   // Waits for a fresh entry into phase p, then for the mux latency
   task automatic at_phase(input logic [2:0] p);
      int n;
      n = 0;
      while (ph == p && n < 400) begin @(posedge sys_clk); #1; n++; end
      while (ph != p && n < 400) begin @(posedge sys_clk); #1; n++; end
      if (n >= 400) begin miscompares++; give_verdict(); end
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      `CHK("pd_rst", 1'b0, pd)
      reg_wr(3'h7, 8'hff);
      foreach (slot_of[k]) if (k < 4) begin
         reg_rd(k == 0 ? 3'h7 : k == 1 ? IDX_SP0 : k == 2 ? IDX_SP1 :
            IDX_MODE, q);
         `CHK("reg_rst", 8'h00, q)
      end
      $display("test reset done");
      for (int r = 0; r < 4; r++) begin
         slots = rows[r][31:16];
         hold = (r == 3) ? 8'h10 : 8'h06;
         for (int k = 0; k < 16; k++) at_phase(k[2:0]);
         for (int k = 0; k < 8; k++) begin
            at_phase(k[2:0]);
            `CHK("mux_a", rows[r][8+k], mux_out_a)
            `CHK("mux_b", rows[r][k], mux_out_b)
            `CHK("oe_a", 1'b1, a_oe)
         end
      end
      $display("test mux rows done");
      fe0 = 1'b1;
      foreach (modes[k]) begin
         fe1 = modes[k][2];
         reg_wr(IDX_MODE, modes[k]);
         reg_rd(IDX_MODE, q);
         `CHK("mode_rd", modes[k], q)
         `CHK("powerdown", modes[k][3], pd)
         `CHK("pp_style", modes[k][2], ps)
         `CHK("pp_bus", modes[k][1], pb)
         `CHK("fifo", {modes[k][0], modes[k][0] & fe1}, {f0, f1})
      end
      $display("test mode done");
      slots = 16'h0000; sp0_irq = 1'b1;
      for (int c = 1; c < 10; c++) begin
         reg_wr(IDX_SP0, c[7:0]);
         at_phase(slot_of[c][2:0]);
         `CHK("route0", 1'b1, slot_of[c][3] ? mux_out_b : mux_out_a)
      end
      reg_wr(IDX_SP1, 8'h09);
      reg_rd(IDX_SP1, q);
      `CHK("route1_rd", 8'h09, q)
      at_phase(3'h7);
      `CHK("sp1_wins", 1'b0, mux_out_a)
      pp_irq = 1'b1; pp_en = 1'b1;
      reg_wr(IDX_PP, 8'h09);
      at_phase(3'h7);
      `CHK("pp_wins", 1'b1, mux_out_a)
      reg_wr(IDX_PP, 8'h00); reg_wr(IDX_SP1, 8'h00); mc0 = 2'h3;
      at_phase(3'h7);
      `CHK("route_gate", 1'b0, mux_out_a)
      $display("test routing done");
      mc0 = 2'h1; mc1 = 2'h0;
      reg_wr(IDX_SP0, 8'h0f);
      reg_rd(IDX_SP0, q);
      `CHK("route0_rd", 8'h0f, q)
      `CHK("alone", 4'hc, {a_oe, mux_out_a, b_oe, mux_out_b})
      `CHK("alone_pp", 2'h3, {i7_oe, i7})
      reg_wr(IDX_SP0, 8'h00); mc1 = 2'h1;
      $display("test stand-alone done");
      mask = 3'h1; slots = 16'h0002;
      repeat (4) at_phase(3'h1);
      slots[1:0] = 2'b01;
      @(posedge sys_clk); #1 slots[1:0] = 2'b10;
      at_phase(3'h0);
      `CHK("stretch_on", 1'b1, mux_out_a)
      at_phase(3'h1);
      `CHK("stretch_low", 1'b0, mux_out_a)
      for (int k = 0; k < 6; k++) at_phase(3'h0);
      `CHK("stretch_off", 1'b0, mux_out_a)
      slots[0] = 1'b1;
      for (int k = 0; k < 6; k++) at_phase(3'h0);
      slots[0] = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK("glitch", 1'b1, mux_out_a)
      slots[0] = 1'b1;
      at_phase(3'h0);
      slots[0] = 1'b0;
      at_phase(3'h0);
      at_phase(3'h0);
      `CHK("trail_on", 1'b1, mux_out_a)
      at_phase(3'h0);
      `CHK("trail_off", 1'b0, mux_out_a)
      $display("test stretch done");
      give_verdict();
   end
endmodule // irq_mux_mode_select_test
`default_nettype wire
